// >>> flash_isp_pkg.sv
// Constants and types for the flash in-system programming register block.
// Assumes an APB master on clk_sys and a flash array port answering with a done pulse.
// Behaviour
// - Read result lands in read-back byte
// - Read-back byte undefined until first read
// - Write programs write byte at address
// - Pulse width comes from pulse-timing register
// - Pulse timing resets to 10 MHz setting
// - Address, data, timing registers read/write
// - Address bytes clear to zero on reset
package flash_isp_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] ADDR_LOW_OFS = 8'h00;
    localparam logic [7:0] ADDR_HIGH_OFS = 8'h04;
    localparam logic [7:0] READ_BACK_OFS = 8'h08;
    localparam logic [7:0] WRITE_DATA_OFS = 8'h0c;
    localparam logic [7:0] PULSE_TIMING_OFS = 8'h10;
    localparam logic [7:0] COMMAND_OFS = 8'h14;
    localparam logic [7:0] STATUS_OFS = 8'h18;

    // ****************************************
    // Reset values and fields
    // ****************************************
    localparam logic [7:0] ADDR_RESET = 8'h00;
    localparam logic [7:0] PULSE_TIMING_10MHZ = 8'h7a;
    localparam logic [15:0] MASS_ERASE_ADDR = 16'h0000;
    localparam logic [15:0] OPTION_SECURED_ADDR = 16'hffff;
    localparam int CMD_W = 2;
    localparam int BUSY_BIT = 0;
    localparam int ERR_BIT = 1;
    // Pulse cycles per timing step
    localparam logic [7:0] CYCLES_PER_STEP = 8'h0a;

    typedef enum logic [1:0] {
        CMD_READ = 2'h0,
        CMD_WRITE = 2'h1,
        CMD_PAGE_ERASE = 2'h2,
        CMD_MASS_ERASE = 2'h3
    } flash_cmd_e;

    typedef struct packed {
        logic req;
        flash_cmd_e cmd;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic pulse;
    } flash_req_s;

endpackage

// >>> flash_isp_regs.sv
// APB register interface sequencing flash reads, writes and erases.
// Assumes the flash array returns a one-cycle done pulse with read data.
//
// The implementer's own choices: the APB slave port and the address map.
module flash_isp_regs
    import flash_isp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output flash_req_s flash_req,
    input wire logic flash_done,
    input wire logic [7:0] flash_rdata
);

    // ****************************************
    // State
    // ****************************************
    typedef enum {IDLE, ACCESS, PULSE} seq_e;

    seq_e state_q;
    logic [7:0] addr_lo_q;
    logic [7:0] addr_hi_q;
    logic [7:0] read_back_q;
    logic [7:0] write_data_q;
    logic [7:0] timing_q;
    logic [7:0] timing_cap_q;
    logic [7:0] step_q;
    logic [7:0] sub_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_mux;
    flash_cmd_e cmd_q;
    flash_cmd_e cmd_new;
    logic err_q;
    logic wr_en;
    logic setup;
    logic start;
    logic refuse;
    logic busy;
    logic hit;
    logic step_end;
    logic pulse_end;
    logic wr_addr_lo;
    logic wr_addr_hi;
    logic wr_write_data;
    logic wr_timing;

    // ****************************************
    // Bus decode
    // ****************************************
    assign wr_en = psel && penable && pwrite;
    assign setup = psel && !penable;
    assign wr_addr_lo = wr_en && paddr == ADDR_LOW_OFS;
    assign wr_addr_hi = wr_en && paddr == ADDR_HIGH_OFS;
    assign wr_write_data = wr_en && paddr == WRITE_DATA_OFS;
    assign wr_timing = wr_en && paddr == PULSE_TIMING_OFS;
    // Command writes while busy are dropped
    assign start = wr_en && paddr == COMMAND_OFS && state_q == IDLE;
    assign cmd_new = flash_cmd_e'(pwdata[CMD_W-1:0]);
    // A zero timing gives no pulse; flag it instead
    assign refuse = cmd_new != CMD_READ && timing_q == 8'h00;
    assign busy = state_q != IDLE;
    // Zero wait states: every register answers in its access cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;

    // ****************************************
    // Read data
    // ****************************************
    always_comb begin
        hit = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            ADDR_LOW_OFS: rd_mux[7:0] = addr_lo_q;
            ADDR_HIGH_OFS: rd_mux[7:0] = addr_hi_q;
            READ_BACK_OFS: rd_mux[7:0] = read_back_q;
            WRITE_DATA_OFS: rd_mux[7:0] = write_data_q;
            PULSE_TIMING_OFS: rd_mux[7:0] = timing_q;
            COMMAND_OFS: rd_mux[CMD_W-1:0] = cmd_q;
            STATUS_OFS: begin
                rd_mux[BUSY_BIT] = busy;
                rd_mux[ERR_BIT] = err_q;
            end
            default: hit = 1'b0;
        endcase
    end

    // Latched in the setup cycle, so the bus sees a flop in the access cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup) begin
            prdata_q <= rd_mux;
        end
    end
    assign prdata = prdata_q;

    // ****************************************
    // Software registers
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            addr_lo_q <= ADDR_RESET;
            addr_hi_q <= ADDR_RESET;
        end else begin
            // Changes during an operation are software's fault, not blocked
            if (wr_addr_lo) begin
                addr_lo_q <= pwdata[7:0];
            end
            if (wr_addr_hi) begin
                addr_hi_q <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            timing_q <= PULSE_TIMING_10MHZ;
        end else if (wr_timing) begin
            timing_q <= pwdata[7:0];
        end
    end

    // No reset: content undefined until written
    always_ff @(posedge clk_sys) begin
        if (wr_write_data) begin
            write_data_q <= pwdata[7:0];
        end
    end

    // No reset: content undefined until a read finishes
    always_ff @(posedge clk_sys) begin
        if (state_q == ACCESS && flash_done && cmd_q == CMD_READ) begin
            read_back_q <= flash_rdata;
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    // Pulse width = timing * step cycles
    assign step_end = state_q == PULSE && sub_q == CYCLES_PER_STEP - 8'h01;
    assign pulse_end = step_end && step_q + 8'h01 == timing_cap_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= IDLE;
        end else begin
            unique case (state_q)
                IDLE: begin
                    if (start && !refuse) begin
                        state_q <= cmd_new == CMD_READ ? ACCESS : PULSE;
                    end
                end
                PULSE: begin
                    if (pulse_end) begin
                        state_q <= ACCESS;
                    end
                end
                ACCESS: begin
                    if (flash_done) begin
                        state_q <= IDLE;
                    end
                end
                default: begin
                    state_q <= IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cmd_q <= CMD_READ;
        end else if (start) begin
            cmd_q <= cmd_new;
        end
    end

    // Captured so a late timing write cannot stretch a running pulse
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            timing_cap_q <= PULSE_TIMING_10MHZ;
        end else if (start) begin
            timing_cap_q <= timing_q;
        end
    end

    // Reports the last accepted command only
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            err_q <= 1'b0;
        end else if (start) begin
            err_q <= refuse;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sub_q <= 8'h00;
        end else if (start || step_end) begin
            sub_q <= 8'h00;
        end else if (state_q == PULSE) begin
            sub_q <= sub_q + 8'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            step_q <= 8'h00;
        end else if (start) begin
            step_q <= 8'h00;
        end else if (step_end) begin
            step_q <= step_q + 8'h01;
        end
    end

    // ****************************************
    // Flash request
    // ****************************************
    always_comb begin
        flash_req.req = state_q == ACCESS;
        flash_req.cmd = cmd_q;
        flash_req.addr = {addr_hi_q, addr_lo_q};
        flash_req.wdata = write_data_q;
        flash_req.pulse = state_q == PULSE;
    end

endmodule

// >>> flash_isp_props.sv
// Port checker for flash_isp_regs, bound at the foot
// Assumes all watched ports sit on clk_sys under the synchronous rst
module flash_isp_props import flash_isp_pkg::*; (
    input wire logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, flash_done,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire flash_req_s flash_req);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire logic acc = psel && penable, req = flash_req.req, pul = flash_req.pulse;
    chk_ready_high: assert property (pready) else $error("no ready");
    chk_bad_addr: assert property (acc && paddr > STATUS_OFS |-> pslverr)
        else $error("no slverr");
    chk_upper_zero: assert property (acc && !pwrite |-> !prdata[31:8]) else $error("upper");
    chk_timing_rst: assert property ($past(rst, 2) && $rose(acc) && paddr == PULSE_TIMING_OFS
        |-> prdata[7:0] == PULSE_TIMING_10MHZ) else $error("timing reset");
    chk_req_hold: assert property (req && !flash_done |=> req) else $error("req drop");
    chk_req_end: assert property (req && flash_done |=> !req) else $error("req stuck");
    chk_pulse_min: assert property ($rose(pul) |-> pul [*8]) else $error("short pulse");
    chk_pulse_access: assert property ($fell(pul) |-> ##[0:1] req) else $error("no access");
    chk_addr_reset: assert property ($past(rst) && !rst |-> flash_req.addr == 16'h0000)
        else $error("addr reset");
    cover property (pul ##1 !pul);
    cover property (req && flash_req.cmd == CMD_MASS_ERASE);
    cover property (req && flash_done);
    cover property (acc && pslverr);
endmodule
bind flash_isp_regs flash_isp_props chk (.clk_sys, .rst, .psel, .penable, .pwrite,
    .pready, .pslverr, .flash_done, .paddr, .prdata, .flash_req);

// >>> flash_array_model.sv
// Flash stand-in: done LAT+1 cycles into req; bytes kept per low address byte
// Assumes one request at a time on clk_sys; erased cells read all ones
module flash_array_model import flash_isp_pkg::*; #(parameter int LAT = 2) (
    input wire logic clk_sys,
    input wire flash_req_s flash_req,
    output logic flash_done = 1'h0,
    output logic [7:0] flash_rdata = 8'h0);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] m [256];
    logic [3:0] n = 4'h0;
    wire logic hit = flash_req.req && !flash_done && n == LAT;
    initial foreach (m[i]) m[i] = 8'hff;
    always @(posedge clk_sys) begin
        n <= flash_req.req && !flash_done ? n + 4'h1 : 4'h0;
        flash_done <= hit;
        // Idle data toggles so a stale byte never passes
        flash_rdata <= hit ? m[flash_req.addr[7:0]] : ~flash_rdata;
        if (hit && flash_req.cmd == CMD_WRITE) begin
            m[flash_req.addr[7:0]] <= flash_req.wdata;
        end
        if (hit && flash_req.cmd == CMD_PAGE_ERASE) begin
            m[flash_req.addr[7:0]] <= 8'hff;
        end
        if (hit && flash_req.cmd == CMD_MASS_ERASE) begin
            foreach (m[i]) m[i] <= 8'hff;
        end
    end
endmodule

// >>> tb.sv
// Bench: APB master and flash stand-in around flash_isp_regs
// Assumes the register map and step size of flash_isp_pkg
module tb import flash_isp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic pready, pslverr, flash_done, se;
    logic [7:0] paddr = 8'h0, flash_rdata;
    logic [31:0] pwdata = 32'h0, prdata, r;
    flash_req_s flash_req;
    int mismatches = 0, cmp_count = 0, pcnt = 0, base = 0;
    logic [47:0] row [4] = '{{ADDR_LOW_OFS, 32'hffffff5a, 8'h5a},
        {ADDR_HIGH_OFS, 32'h1c7, 8'hc7},
        {WRITE_DATA_OFS, 32'h3c, 8'h3c}, {PULSE_TIMING_OFS, 32'h2, 8'h2}};
    flash_isp_regs uut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .flash_req, .flash_done, .flash_rdata);
    flash_array_model fm (.clk_sys, .flash_req, .flash_done, .flash_rdata);
    initial forever #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) pcnt += flash_req.pulse === 1'h1;
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
        @(posedge clk_sys) penable <= 1'h1;
        do @(posedge clk_sys); while (pready !== 1'h1);
        r = prdata;
        se = pslverr;
        {psel, penable} <= 2'h0;
        @(posedge clk_sys);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) $display("[ERR] %0t got %h exp %h", $time, g, e);
        mismatches += g !== e;
    endtask
    task automatic op(input logic [1:0] c);
        apb(1'h1, COMMAND_OFS, {30'h0, c});
        do apb(1'h0, STATUS_OFS, 32'h0); while (r[BUSY_BIT] !== 1'h0);
    endtask
    task automatic conclude;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial #100000 begin
        mismatches++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'h0;
        foreach (row[i]) begin
            apb(1'h1, row[i][47:40], row[i][39:8]);
            apb(1'h0, row[i][47:40], 32'h0);
            chk(r, {24'h0, row[i][7:0]});
        end
        apb(1'h1, 8'h1c, 32'h0);
        chk({31'h0, se}, 32'h1);
        $display("register table done");
        op(CMD_WRITE);
        op(CMD_READ);
        apb(1'h0, READ_BACK_OFS, 32'h0);
        chk(r, 32'h3c);
        apb(1'h1, ADDR_LOW_OFS, 32'h5b);
        op(CMD_READ);
        apb(1'h0, READ_BACK_OFS, 32'h0);
        chk(r, 32'hff);
        apb(1'h1, ADDR_LOW_OFS, 32'h5a);
        op(CMD_PAGE_ERASE);
        op(CMD_READ);
        apb(1'h0, READ_BACK_OFS, 32'h0);
        chk(r, 32'hff);
        chk(pcnt, 32'h4 * CYCLES_PER_STEP);
        $display("operations done");
        rst <= 1'h1;
        repeat (10) @(posedge clk_sys);
        rst <= 1'h0;
        apb(1'h0, PULSE_TIMING_OFS, 32'h0);
        chk(r, {24'h0, PULSE_TIMING_10MHZ});
        apb(1'h0, ADDR_LOW_OFS, 32'h0);
        chk(r, {24'h0, ADDR_RESET});
        apb(1'h0, ADDR_HIGH_OFS, 32'h0);
        chk(r, {24'h0, ADDR_RESET});
        apb(1'h1, WRITE_DATA_OFS, 32'h96);
        base = pcnt;
        op(CMD_WRITE);
        chk(pcnt - base, {24'h0, PULSE_TIMING_10MHZ} * CYCLES_PER_STEP);
        op(CMD_READ);
        apb(1'h0, READ_BACK_OFS, 32'h0);
        chk(r, 32'h96);
        op(CMD_MASS_ERASE);
        op(CMD_READ);
        apb(1'h0, READ_BACK_OFS, 32'h0);
        chk(r, 32'hff);
        $display("reset and erase done");
        apb(1'h1, PULSE_TIMING_OFS, 32'h0);
        base = pcnt;
        op(CMD_PAGE_ERASE);
        chk(r & 32'h3, 32'h2);
        chk(pcnt - base, 32'h0);
        $display("refusal done");
        conclude();
    end
endmodule
